// ### hdl/cgc_pkg.sv
package cgc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CGC_ADDR_CONTROL  = 8'h04;
  localparam logic [7:0] CGC_ADDR_DIVISION = 8'h08;
  localparam logic [7:0] CGC_ADDR_USAGE    = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int CGC_NUM_GEN     = 8;
  localparam int CGC_IDX_LSB     = 0;
  localparam int CGC_IDX_W       = 4;
  localparam int CGC_SRC_LSB     = 8;
  localparam int CGC_SRC_W       = 5;
  localparam int CGC_EN_BIT      = 16;
  localparam int CGC_DIVIDE_SELECT_BIT  = 20;
  localparam int CGC_DIV_LSB     = 8;
  localparam int CGC_DIV_W       = 16;
  localparam int CGC_FACT_W      = 18;

  // Implemented division width of each generator
  localparam int CGC_DIVW_GEN0   = 8;
  localparam int CGC_DIVW_GEN1   = 16;
  localparam int CGC_DIVW_GEN2   = 5;
  localparam int CGC_DIVW_OTHER  = 8;

  // ----------------------------------------------------------------
  // Source codes and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] CGC_SRC_LAST      = 5'h07;
  localparam logic [4:0] CGC_SRC_GEN0_RST  = 5'h06;
  localparam logic [4:0] CGC_SRC_GEN2_RST  = 5'h03;
  localparam logic [3:0] CGC_IDX_RESERVED  = 4'h8;
  localparam logic [3:0] CGC_GEN_ZERO      = 4'h0;
  localparam logic [3:0] CGC_GEN_TWO       = 4'h2;

  typedef enum logic [4:0] {
    CGC_SRC_CRYSTAL = 5'h00,
    CGC_SRC_PAD     = 5'h01,
    CGC_SRC_GEN1    = 5'h02,
    CGC_SRC_ULP32K  = 5'h03,
    CGC_SRC_INT32K  = 5'h04,
    CGC_SRC_XTAL32K = 5'h05,
    CGC_SRC_INT8M   = 5'h06,
    CGC_SRC_FLL     = 5'h07
  } cgc_source_t;

  // Per-generator settings
  typedef struct packed {
    logic        divide_select;
    logic        generator_enable;
    logic [4:0]  source_select;
    logic [15:0] division;
  } cgc_gen_cfg_t;

  // Register port bundle
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cgc_bus_req_t;

endpackage

// ### hdl/clock_generator_config.sv
`timescale 1ns/10ps

// Contract
// RQ1: Source field bits 12:8 picks generator input; codes 0x08-0x1F reserved.
// RQ2: Control index bits 3:0 chooses generator written or read; 0x8-0xF reserved.
// RQ3: Power reset restores every generator control to its default, RTC one included.
// RQ4: User reset restores generator 0 always, others only if unused by RTC/lock.
// RQ5: Division bits 23:8 set factor; bits above implemented width are ignored.
// RQ6: Division widths: gen0 8, gen1 16, gen2 5, others 8 bits.
// RQ7: Division index bits 3:0 selects generator 0..7; 0x8-0xF reserved.
// RQ8: Power reset clears every generator division; read word equals the index.
// RQ9: User reset clears gen0 division always, others only if unused by RTC/lock.
// RQ10: Divide select clear: divide by factor (0,1 none); set: by 2^(factor+1). Code stops at 2^17 for factor 16 and up.
// RQ11: Control bit 16 enables the indexed generator.
// RQ12: Indexed access; write updates named generator; read uses last written index.
module cgc_clock_generator_config
  import cgc_pkg::*;
(
  // Clock and power reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // User reset request, synchronous one-cycle pulse
  input  wire logic                        user_reset,
  // Usage of each generator by the real-time counter and locked channels
  input  wire logic [CGC_NUM_GEN-1:0]      rtc_source,
  input  wire logic [CGC_NUM_GEN-1:0]      locked_source,
  // Register port
  input  wire cgc_bus_req_t                bus_req,
  output logic [31:0]                      rd_data,
  // Generator configuration outputs
  output logic [CGC_NUM_GEN-1:0]           gen_enable,
  output logic [CGC_NUM_GEN*5-1:0]         gen_source,
  output logic [CGC_NUM_GEN-1:0]           gen_source_valid,
  output logic [CGC_NUM_GEN*CGC_FACT_W-1:0] gen_factor
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  cgc_gen_cfg_t cfg_reg [CGC_NUM_GEN];
  logic [3:0]   ctrl_idx_reg;
  logic [3:0]   div_idx_reg;

  logic         wr_ctrl;
  logic         wr_div;
  logic [3:0]   wr_ctrl_idx;
  logic [3:0]   wr_div_idx;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Address match only; the index is judged further down
  assign wr_ctrl     = bus_req.wr && (bus_req.addr == CGC_ADDR_CONTROL);
  assign wr_div      = bus_req.wr && (bus_req.addr == CGC_ADDR_DIVISION);
  assign wr_ctrl_idx = bus_req.wdata[CGC_IDX_LSB +: CGC_IDX_W];
  assign wr_div_idx  = bus_req.wdata[CGC_IDX_LSB +: CGC_IDX_W];

  // ----------------------------------------------------------------
  // Write fields and acceptance
  // ----------------------------------------------------------------
  logic [CGC_SRC_W-1:0]   wr_src_field;
  logic                   wr_en_field;
  logic                   wr_divide_select_field;
  logic [CGC_DIV_W-1:0]   wr_div_field;
  logic                   ctrl_taken;
  logic                   div_taken;
  logic [CGC_NUM_GEN-1:0] ctrl_hit;
  logic [CGC_NUM_GEN-1:0] div_hit;
  logic [CGC_NUM_GEN-1:0] spare_vec;

  // Control word fields; all other bits of the word are dropped
  assign wr_src_field    = bus_req.wdata[CGC_SRC_LSB +: CGC_SRC_W]; // [RQ1]
  assign wr_en_field     = bus_req.wdata[CGC_EN_BIT]; // [RQ11]
  assign wr_divide_select_field = bus_req.wdata[CGC_DIVIDE_SELECT_BIT]; // [RQ10]
  // Division word field, still unmasked here
  assign wr_div_field    = bus_req.wdata[CGC_DIV_LSB +: CGC_DIV_W]; // [RQ5]

  // A user reset in the same cycle swallows the write
  assign ctrl_taken = wr_ctrl && !user_reset;
  assign div_taken  = wr_div && !user_reset;

  // One-hot generator select; reserved index values reach no generator
  always_comb begin
    ctrl_hit = '0;
    div_hit  = '0;
    if (ctrl_taken && (wr_ctrl_idx < CGC_IDX_RESERVED)) begin // [RQ2]
      ctrl_hit[wr_ctrl_idx[2:0]] = 1'b1;
    end
    if (div_taken && (wr_div_idx < CGC_IDX_RESERVED)) begin // [RQ7]
      div_hit[wr_div_idx[2:0]] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // User reset spare set
  // ----------------------------------------------------------------
  // Generators a user reset must leave alone; generator 0 is never spared,
  // so the system clock always comes back to its known source
  always_comb begin
    spare_vec    = rtc_source | locked_source; // [RQ4] [RQ9]
    spare_vec[0] = 1'b0;
  end

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Implemented division width per generator
  function automatic int cgc_div_width(input int g);
    begin
      unique case (g)
        0:       cgc_div_width = CGC_DIVW_GEN0;
        1:       cgc_div_width = CGC_DIVW_GEN1;
        2:       cgc_div_width = CGC_DIVW_GEN2;
        default: cgc_div_width = CGC_DIVW_OTHER;
      endcase
    end
  endfunction

  // Mask that keeps only the division bits this generator implements
  function automatic logic [15:0] cgc_div_mask(input int g);
    begin
      cgc_div_mask = 16'((32'h1 << cgc_div_width(g)) - 32'h1); // [RQ6]
    end
  endfunction

  // Default control settings of one generator
  function automatic cgc_gen_cfg_t cgc_default(input int g, input logic [15:0] div_keep);
    cgc_gen_cfg_t c;
    begin
      c = '0;
      c.division = div_keep;
      if (g == 0) begin
        c.generator_enable = 1'b1;
        c.source_select    = CGC_SRC_GEN0_RST;
      end else if (g == 2) begin
        c.generator_enable = 1'b1;
        c.source_select    = CGC_SRC_GEN2_RST;
      end
      cgc_default = c;
    end
  endfunction

  // ----------------------------------------------------------------
  // Index registers
  // ----------------------------------------------------------------
  // Last written index kept so a read returns that generator; a reserved
  // index is kept too, so software can read back what it wrote
  logic [3:0] ctrl_idx_next;
  logic [3:0] div_idx_next;

  // User reset returns both pointers to generator 0
  always_comb begin
    ctrl_idx_next = ctrl_idx_reg;
    div_idx_next  = div_idx_reg;
    if (user_reset) begin
      ctrl_idx_next = CGC_GEN_ZERO;
      div_idx_next  = CGC_GEN_ZERO;
    end else begin
      if (wr_ctrl) begin
        ctrl_idx_next = wr_ctrl_idx; // [RQ2] [RQ12]
      end
      if (wr_div) begin
        div_idx_next = wr_div_idx; // [RQ7] [RQ12]
      end
    end
  end

  // Pointer registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_idx_reg <= CGC_GEN_ZERO;
      div_idx_reg  <= CGC_GEN_ZERO;
    end else begin
      ctrl_idx_reg <= ctrl_idx_next;
      div_idx_reg  <= div_idx_next;
    end
  end

  // ----------------------------------------------------------------
  // Per-generator settings
  // ----------------------------------------------------------------
  // User reset spares generators other than 0 feeding the RTC or a locked channel
  for (genvar g = 0; g < CGC_NUM_GEN; g++) begin : g_gen
    cgc_gen_cfg_t          cfg_next;
    logic [CGC_FACT_W-1:0] factor_next;

    // User reset outweighs a write, a write outweighs hold
    always_comb begin
      cfg_next = cfg_reg[g];
      if (user_reset) begin
        if (!spare_vec[g]) begin
          cfg_next = cgc_default(g, 16'h0000); // [RQ4] [RQ9]
        end
      end else begin
        if (ctrl_hit[g]) begin
          cfg_next.source_select    = wr_src_field; // [RQ1]
          cfg_next.generator_enable = wr_en_field; // [RQ11]
          cfg_next.divide_select    = wr_divide_select_field; // [RQ10]
        end
        if (div_hit[g]) begin
          // Upper bits beyond the generator's width are dropped
          cfg_next.division = wr_div_field & cgc_div_mask(g); // [RQ5] [RQ6]
        end
      end
    end

    // Settings register of this generator
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        cfg_reg[g] <= cgc_default(g, 16'h0000); // [RQ3] [RQ8]
      end else begin
        cfg_reg[g] <= cfg_next;
      end
    end

    // --------------------------------------------------------------
    // Effective factor
    // --------------------------------------------------------------
    // With divide select clear, 0 and 1 both mean pass-through. The power-of-two mode saturates at
    // the top bit: that is the widest factor the output port can carry
    always_comb begin
      factor_next = CGC_FACT_W'(1);
      if (cfg_reg[g].divide_select) begin
        if (cfg_reg[g].division >= 16'(CGC_FACT_W - 2)) begin
          factor_next = {1'b1, {(CGC_FACT_W - 1){1'b0}}}; // [RQ6] [RQ10]
        end else begin
          factor_next = CGC_FACT_W'(32'h2 << cfg_reg[g].division[3:0]); // [RQ10]
        end
      end else if (cfg_reg[g].division > 16'h0001) begin
        factor_next = CGC_FACT_W'(cfg_reg[g].division); // [RQ10]
      end
    end

    // Factor output register
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        gen_factor[g*CGC_FACT_W +: CGC_FACT_W] <= '0;
      end else begin
        gen_factor[g*CGC_FACT_W +: CGC_FACT_W] <= factor_next;
      end
    end

    // Enable and source to the clock switch
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        gen_enable[g]                        <= 1'b0;
        gen_source[g*CGC_SRC_W +: CGC_SRC_W] <= 5'h00;
        gen_source_valid[g]                  <= 1'b0;
      end else begin
        gen_enable[g]                        <= cfg_reg[g].generator_enable; // [RQ11]
        gen_source[g*CGC_SRC_W +: CGC_SRC_W] <= cfg_reg[g].source_select;
        // Reserved source codes select nothing
        gen_source_valid[g]                  <= (cfg_reg[g].source_select <= CGC_SRC_LAST); // [RQ1]
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Reserved index reads as the bare index with no settings
  logic [31:0]  ctrl_word;
  logic [31:0]  div_word;
  logic [31:0]  usage_word;
  logic [31:0]  rd_data_next;
  cgc_gen_cfg_t ctrl_view;
  cgc_gen_cfg_t div_view;

  // Settings of the generators that the two pointers name
  assign ctrl_view = cfg_reg[ctrl_idx_reg[2:0]];
  assign div_view  = cfg_reg[div_idx_reg[2:0]];

  // Control word: index, source, enable and divide select only
  always_comb begin
    ctrl_word                           = 32'h0000_0000;
    ctrl_word[CGC_IDX_LSB +: CGC_IDX_W] = ctrl_idx_reg; // [RQ12]
    if (ctrl_idx_reg < CGC_IDX_RESERVED) begin // [RQ2]
      ctrl_word[CGC_SRC_LSB +: CGC_SRC_W] = ctrl_view.source_select;
      ctrl_word[CGC_EN_BIT]               = ctrl_view.generator_enable;
      ctrl_word[CGC_DIVIDE_SELECT_BIT]           = ctrl_view.divide_select;
    end
  end

  // Division word: index and the stored, already masked factor
  always_comb begin
    div_word                           = 32'h0000_0000;
    div_word[CGC_IDX_LSB +: CGC_IDX_W] = div_idx_reg; // [RQ12]
    if (div_idx_reg < CGC_IDX_RESERVED) begin // [RQ7]
      div_word[CGC_DIV_LSB +: CGC_DIV_W] = div_view.division; // [RQ8]
    end
  end

  // Usage word lets software see which generators the RTC and locked channels use; a user reset spares those but generator 0
  assign usage_word = {16'h0000, locked_source, rtc_source};

  // ----------------------------------------------------------------
  // Read select
  // ----------------------------------------------------------------
  // Read data stands for one cycle and is zero otherwise, so a stale word
  // can never be mistaken for a fresh answer
  always_comb begin
    rd_data_next = 32'h0000_0000;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        CGC_ADDR_CONTROL:  rd_data_next = ctrl_word;
        CGC_ADDR_DIVISION: rd_data_next = div_word;
        CGC_ADDR_USAGE:    rd_data_next = usage_word;
        default:           rd_data_next = 32'h0000_0000;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data <= 32'h0000_0000;
    end else begin
      rd_data <= rd_data_next;
    end
  end

endmodule

// ### bench/cgc_checker.sv
`timescale 1ns/10ps
// ----------------
// Port checker
// ----------------
module cgc_checker
  import cgc_pkg::*;
(
  // Clock, resets, usage
  input wire logic         clk_sys,
  input wire logic         rst,
  input wire logic         user_reset,
  input wire logic [7:0]   rtc_source,
  input wire logic [7:0]   locked_source,
  // Register port
  input wire cgc_bus_req_t bus_req,
  input wire logic [31:0]  rd_data,
  // Generator outputs
  input wire logic [7:0]   gen_enable,
  input wire logic [39:0]  gen_source,
  input wire logic [7:0]   gen_source_valid,
  input wire logic [143:0] gen_factor
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Write to a real generator; a user reset would swallow it
  sequence ctl_wr;
    bus_req.wr && bus_req.addr == CGC_ADDR_CONTROL && !bus_req.wdata[3] && !user_reset;
  endsequence
  // Idle cycle, then a control read
  sequence gap_rd;
    !bus_req.wr && !user_reset ##1 bus_req.rd && bus_req.addr == CGC_ADDR_CONTROL;
  endsequence
  AST_CTL_EN: assert property (ctl_wr |-> ##2
    gen_enable[$past(bus_req.wdata[2:0], 2)] == $past(bus_req.wdata[16], 2)) else $error("bad enable");
  AST_CTL_SRC: assert property (ctl_wr |-> ##2
    gen_source[5*$past(bus_req.wdata[2:0], 2) +: 5] == $past(bus_req.wdata[12:8], 2)) else $error("bad source");
  AST_RD_CTL: assert property (ctl_wr ##1 gap_rd |=>
    rd_data == ($past(bus_req.wdata, 3) & 32'h0011_1F0F)) else $error("bad control read");
  // Outputs trail reset release by one edge, so that edge is skipped
  AST_SRC_VALID: assert property (!$past(rst) |->
    gen_source_valid[3] == (gen_source[19:15] <= CGC_SRC_LAST)) else $error("bad source valid");
  AST_PWR_DEF: assert property ($past(rst) |=>
    gen_enable == 8'h05 && gen_factor[35:18] == 18'h1) else $error("bad power defaults");
  AST_USR_GEN0: assert property (user_reset |-> ##2
    gen_enable[0] && gen_source[4:0] == CGC_SRC_GEN0_RST && gen_factor[17:0] == 18'h1) else $error("gen0 kept");
  AST_USR_SPARE: assert property (user_reset && (rtc_source[1] || locked_source[1]) |=> ##1
    $stable(gen_source[9:5]) && $stable(gen_factor[35:18])) else $error("spared gen changed");
  AST_USR_FREE: assert property (user_reset && !rtc_source[7] && !locked_source[7] |-> ##2
    !gen_enable[7] && gen_factor[143:126] == 18'h1) else $error("free gen kept");
endmodule

bind cgc_clock_generator_config cgc_checker cgc_checker_i (.clk_sys, .rst, .user_reset, .rtc_source,
  .locked_source, .bus_req, .rd_data, .gen_enable, .gen_source, .gen_source_valid, .gen_factor);

// ### bench/cgc_clock_generator_config_tb_top.sv
`timescale 1ns/10ps
// ----------------
// Register bench
// ----------------
module cgc_clock_generator_config_tb_top
  import cgc_pkg::*;
;
  logic         clk_sys = 1'b0;
  logic         rst = 1'b1;
  logic         user_reset = 1'b0;
  logic [7:0]   rtc_source = 8'h00;
  logic [7:0]   locked_source = 8'h00;
  cgc_bus_req_t bus_req = '0;
  logic [31:0]  rd_data;
  logic [7:0]   gen_enable;
  logic [39:0]  gen_source;
  logic [7:0]   gen_source_valid;
  logic [143:0] gen_factor;
  int           mismatches = 0;
  int           checks = 0;

  cgc_clock_generator_config cgc_clock_generator_config_i (.clk_sys, .rst, .user_reset, .rtc_source,
    .locked_source, .bus_req, .rd_data, .gen_enable, .gen_source, .gen_source_valid, .gen_factor);

  // 200 MHz clock
  initial forever #2.5 clk_sys = ~clk_sys;

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Cycle ceiling; the tests need under 200 cycles
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    conclude();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One access; a read compares against d, sampled #1 after the data edge to avoid races
  task automatic acc(input logic rd, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req <= '{a, d, !rd, rd};
    @(posedge clk_sys);
    bus_req <= '0;
    #1;
    if (rd) chk(rd_data, d);
  endtask

  // Outputs lag a register update by one edge
  task automatic settle();
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic gchk(input int g, input logic en, input logic [4:0] src, input logic [17:0] fac);
    chk(32'({gen_enable[g], gen_source[g*5 +: 5], gen_factor[g*18 +: 18]}), 32'({en, src, fac}));
  endtask

  task automatic pwr_chk();
    for (int g = 0; g < 8; g++) gchk(g, g == 0 || g == 2, g == 0 ? 5'h06 : g == 2 ? 5'h03 : 5'h00, 18'h1);
    acc(1'b1, CGC_ADDR_CONTROL, 32'h00010600);
    acc(1'b1, CGC_ADDR_DIVISION, 32'h00000000);
  endtask

  // Main sequence
  initial begin
    logic [31:0] d;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    settle();
    pwr_chk();
    $display("power reset test done");
    for (int s = 0; s < 10; s++) begin
      d = (32'(s & 1) << 16) | (32'(s) << 8) | 32'h3;
      acc(1'b0, CGC_ADDR_CONTROL, d);
      acc(1'b1, CGC_ADDR_CONTROL, d);
      settle();
      gchk(3, 1'(s & 1), 5'(s), 18'h1);
    end
    $display("source test done");
    for (int g = 0; g < 8; g++) begin
      d = g == 1 ? 32'hFFFF : g == 2 ? 32'h1F : 32'hFF;
      acc(1'b0, CGC_ADDR_DIVISION, 32'h00FFFF00 | 32'(g));
      acc(1'b1, CGC_ADDR_DIVISION, (d << 8) | 32'(g));
      settle();
      chk(32'(gen_factor[g*18 +: 18]), d);
    end
    acc(1'b0, CGC_ADDR_DIVISION, 32'h00000304);
    acc(1'b0, CGC_ADDR_CONTROL, 32'h00110004);
    acc(1'b0, CGC_ADDR_DIVISION, 32'h00000105);
    settle();
    chk(32'(gen_factor[4*18 +: 18]), 32'h10);
    chk(32'(gen_factor[5*18 +: 18]), 32'h1);
    acc(1'b0, CGC_ADDR_DIVISION, 32'h00001001);
    acc(1'b0, CGC_ADDR_CONTROL, 32'h00100001);
    settle();
    chk(32'(gen_factor[1*18 +: 18]), 32'h20000);
    acc(1'b0, CGC_ADDR_CONTROL, 32'h00000001);
    acc(1'b0, CGC_ADDR_DIVISION, 32'h00FFFF01);
    $display("division test done");
    acc(1'b0, CGC_ADDR_CONTROL, 32'h00011F08);
    acc(1'b1, CGC_ADDR_CONTROL, 32'h00000008);
    acc(1'b0, CGC_ADDR_DIVISION, 32'h0000FF0F);
    acc(1'b1, CGC_ADDR_DIVISION, 32'h0000000F);
    acc(1'b0, 8'h10, 32'h00010001);
    acc(1'b1, 8'h10, 32'h00000000);
    settle();
    gchk(1, 1'b0, 5'h00, 18'hFFFF);
    $display("reserved test done");
    // Gen 1 feeds the counter, gen 3 a locked channel
    @(posedge clk_sys);
    rtc_source <= 8'h02;
    locked_source <= 8'h08;
    acc(1'b1, CGC_ADDR_USAGE, 32'h00000802);
    for (int g = 0; g < 8; g++) acc(1'b0, CGC_ADDR_CONTROL, 32'h00010500 | 32'(g));
    @(posedge clk_sys);
    user_reset <= 1'b1;
    @(posedge clk_sys);
    user_reset <= 1'b0;
    settle();
    for (int g = 0; g < 8; g++) begin
      gchk(g, g < 4, g == 0 ? 5'h06 : g == 2 ? 5'h03 : (g == 1 || g == 3) ? 5'h05 : 5'h00,
           g == 1 ? 18'hFFFF : g == 3 ? 18'hFF : 18'h1);
    end
    acc(1'b1, CGC_ADDR_CONTROL, 32'h00010600);
    acc(1'b1, CGC_ADDR_DIVISION, 32'h00000000);
    $display("user reset test done");
    // Power reset ignores the counter's claim
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    settle();
    pwr_chk();
    $display("second power reset test done");
    conclude();
  end
endmodule
